//--- aes_pkg.sv
// Constants for the ACL entry staging bytes and byte-select block.
// Assumes a 40 MHz APB clock; register byte address is four times index.
package aes_pkg;
   // Clock and transfer timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int XFER_TIME_NS = 100;
   localparam int XFER_CYCLES =
      (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] XFER_CNT = 3'(XFER_CYCLES);

   // Register indices; byte address is index * 4
   localparam logic [11:0] IDX_MAC_BYTE_2 = 12'h604;
   localparam logic [11:0] IDX_MAC_BYTE_1 = 12'h605;
   localparam logic [11:0] IDX_MAC_BYTE_0_HI = 12'h606;
   localparam logic [11:0] IDX_MAC_BYTE_0_LO = 12'h607;
   localparam logic [11:0] IDX_ETHERTYPE_HI = 12'h608;
   localparam logic [11:0] IDX_ETHERTYPE_LO = 12'h609;
   localparam logic [11:0] IDX_PRIORITY_ACTION = 12'h60A;
   localparam logic [11:0] IDX_REMARK_MAP_MODE = 12'h60B;
   localparam logic [11:0] IDX_SPARE_BYTE = 12'h60C;
   localparam logic [11:0] IDX_FORWARD_PORTS = 12'h60D;
   localparam logic [11:0] IDX_RULESET_HI = 12'h60E;
   localparam logic [11:0] IDX_RULESET_LO = 12'h60F;
   localparam logic [11:0] IDX_BYTE_SELECT_HI = 12'h610;
   localparam logic [11:0] IDX_BYTE_SELECT_LO = 12'h611;
   localparam logic [11:0] IDX_ACCESS_CTRL = 12'h612;
   localparam logic [11:0] IDX_STAGE_BASE = 12'h600;

   // Staging byte range held here and table depth
   localparam int STG_FIRST = 4;
   localparam int STG_LAST = 15;
   localparam int TBL_DEPTH = 16;

   // Writable bits per staging byte
   localparam logic [7:0] MASK_FULL = 8'hFF;
   localparam logic [7:0] MASK_REMARK_MAP = 8'hE0;
   localparam logic [7:0] MASK_SPARE = 8'h00;
   localparam logic [7:0] MASK_FORWARD = 8'h07;
   localparam int BYTE_PRIORITY = 10;
   localparam int BYTE_REMARK = 11;
   localparam int BYTE_SPARE = 12;
   localparam int BYTE_FORWARD = 13;

   // Access control field positions and reset values
   localparam int CTRL_WSTAT_BIT = 6;
   localparam int CTRL_RSTAT_BIT = 5;
   localparam int CTRL_DIR_BIT = 4;
   localparam logic STAT_RESET = 1'b1;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   typedef enum logic {AES_IDLE, AES_BUSY} aes_state_e;
endpackage : aes_pkg

//--- aes_regs.sv
// APB register slave holding ACL staging bytes, byte selects and the
// per-port rule table. Assumes pclk-domain APB master and lookup user.
//
// Overview of operation
// - Low select write launches the table transfer
// - Twelve select bits (11:0) include or exclude bytes 4-F
// - High select bit 0 picks byte 7
// - Low select bit 0 picks byte F
// - Remark priority split over bytes A and B
// - Byte D holds forward bits ports 1-3
// - Write status clear during write, reset one
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module aes_regs
   import aes_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] lookup_idx,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [2:0] lookup_fwd,
   output logic [2:0] lookup_remark,
   output logic xfer_busy
);

   localparam int XFER_LAT = XFER_CYCLES;
   localparam int XFER_LAT_M1 = XFER_CYCLES - 1;

   logic [7:0] stg_reg [STG_FIRST:STG_LAST];
   logic [7:0] tbl_mem [0:TBL_DEPTH-1][STG_FIRST:STG_LAST];
   logic [7:0] sel_hi_reg;
   logic [7:0] sel_lo_reg;
   logic [3:0] idx_reg;
   logic dir_reg;
   logic wstat_reg;
   logic rstat_reg;
   aes_state_e st_reg;
   logic [2:0] cnt_reg;
   logic [15:0] op_en_reg;
   logic [3:0] op_idx_reg;
   logic op_dir_reg;
   logic acc;
   logic wr_acc;
   logic launch;
   logic done;
   logic [11:0] widx;

   function automatic logic [11:0] reg_index(input logic [15:0] a);
      reg_index = a[13:2];
   endfunction : reg_index

   function automatic logic is_mapped(input logic [15:0] a);
      logic [11:0] i;
      i = reg_index(a);
      is_mapped = (a[15:14] == 2'h0) && (a[1:0] == 2'h0) &&
                  (i >= IDX_MAC_BYTE_2) && (i <= IDX_ACCESS_CTRL);
   endfunction : is_mapped

   // Staging byte k is picked by combined select bit 15-k
   function automatic logic byte_sel(input logic [15:0] en, input int k);
      byte_sel = en[15 - k];
   endfunction : byte_sel

   function automatic logic [7:0] byte_mask(input int k);
      if (k == BYTE_REMARK) begin
         byte_mask = MASK_REMARK_MAP;
      end else if (k == BYTE_SPARE) begin
         byte_mask = MASK_SPARE;
      end else if (k == BYTE_FORWARD) begin
         byte_mask = MASK_FORWARD;
      end else begin
         byte_mask = MASK_FULL;
      end
   endfunction : byte_mask

   function automatic logic [31:0] rd_value(input logic [15:0] a);
      logic [11:0] i;
      logic [3:0] k;
      i = reg_index(a);
      k = i[3:0];
      rd_value = RDATA_RESET;
      if (!is_mapped(a)) begin
         rd_value = RDATA_RESET;
      end else if (i == IDX_BYTE_SELECT_HI) begin
         rd_value[7:0] = sel_hi_reg;
      end else if (i == IDX_BYTE_SELECT_LO) begin
         rd_value[7:0] = sel_lo_reg;
      end else if (i == IDX_ACCESS_CTRL) begin
         rd_value[CTRL_WSTAT_BIT] = wstat_reg;
         rd_value[CTRL_RSTAT_BIT] = rstat_reg;
         rd_value[CTRL_DIR_BIT] = dir_reg;
         rd_value[3:0] = idx_reg;
      end else begin
         rd_value[7:0] = stg_reg[k];
      end
   endfunction : rd_value

   assign acc = psel && penable && pready;
   assign wr_acc = acc && pwrite && is_mapped(paddr);
   assign widx = reg_index(paddr);
   // Launch while busy is dropped; the select value is still stored
   assign launch = wr_acc && (widx == IDX_BYTE_SELECT_LO) &&
                   (st_reg == AES_IDLE);
   assign done = (st_reg == AES_BUSY) && (cnt_reg == 3'h1);

   // APB answer: no wait state; every output is a flop loaded in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= RDATA_RESET;
      end else if (ce) begin
         pready <= psel && !penable;
         if (psel && !penable) begin
            pslverr <= !is_mapped(paddr);
            prdata <= pwrite ? RDATA_RESET : rd_value(paddr);
         end
      end
   end

   // Byte selects and access control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_hi_reg <= BYTE_RESET;
         sel_lo_reg <= BYTE_RESET;
         idx_reg <= 4'h0;
         dir_reg <= 1'b0;
      end else if (ce && wr_acc) begin
         if (widx == IDX_BYTE_SELECT_HI) begin
            sel_hi_reg <= pwdata[7:0];
         end
         if (widx == IDX_BYTE_SELECT_LO) begin
            sel_lo_reg <= pwdata[7:0];
         end
         if (widx == IDX_ACCESS_CTRL) begin
            dir_reg <= pwdata[CTRL_DIR_BIT];
            idx_reg <= pwdata[3:0];
         end
      end
   end

   // Transfer sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= AES_IDLE;
         cnt_reg <= 3'h0;
         op_en_reg <= 16'h0000;
         op_idx_reg <= 4'h0;
         op_dir_reg <= 1'b0;
      end else if (ce) begin
         unique case (st_reg)
            AES_IDLE: begin
               if (launch) begin
                  st_reg <= AES_BUSY;
                  cnt_reg <= XFER_CNT;
                  op_en_reg <= {sel_hi_reg, pwdata[7:0]};
                  op_idx_reg <= idx_reg;
                  op_dir_reg <= dir_reg;
               end
            end
            AES_BUSY: begin
               cnt_reg <= cnt_reg - 3'h1;
               if (done) begin
                  st_reg <= AES_IDLE;
               end
            end
         endcase
      end
   end

   // Completion flags, set to one out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wstat_reg <= STAT_RESET;
         rstat_reg <= STAT_RESET;
         xfer_busy <= 1'b0;
      end else if (ce) begin
         xfer_busy <= launch || (st_reg == AES_BUSY && !done);
         if (launch && dir_reg) begin
            wstat_reg <= 1'b0;
         end else if (done && op_dir_reg) begin
            wstat_reg <= 1'b1;
         end
         if (launch && !dir_reg) begin
            rstat_reg <= 1'b0;
         end else if (done && !op_dir_reg) begin
            rstat_reg <= 1'b1;
         end
      end
   end

   // Staging bytes; a finishing read wins over a same-cycle bus write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = STG_FIRST; k <= STG_LAST; k++) begin
            stg_reg[k] <= BYTE_RESET;
         end
      end else if (ce) begin
         for (int k = STG_FIRST; k <= STG_LAST; k++) begin
            if (done && !op_dir_reg && byte_sel(op_en_reg, k)) begin
               stg_reg[k] <= tbl_mem[op_idx_reg][k] & byte_mask(k);
            end else if (wr_acc && widx == IDX_STAGE_BASE + 12'(k)) begin
               // Remark bits land in A[1:0] and B[7]
               stg_reg[k] <= pwdata[7:0] & byte_mask(k);
            end
         end
      end
   end

   // Rule table, written only in selected byte lanes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int e = 0; e < TBL_DEPTH; e++) begin
            for (int k = STG_FIRST; k <= STG_LAST; k++) begin
               tbl_mem[e][k] <= BYTE_RESET;
            end
         end
      end else if (ce && done && op_dir_reg) begin
         for (int k = STG_FIRST; k <= STG_LAST; k++) begin
            if (byte_sel(op_en_reg, k)) begin
               tbl_mem[op_idx_reg][k] <= stg_reg[k];
            end
         end
      end
   end

   // Entry fields for the matching engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lookup_fwd <= 3'h0;
         lookup_remark <= 3'h0;
      end else if (ce) begin
         lookup_fwd <= tbl_mem[lookup_idx][BYTE_FORWARD][2:0];
         lookup_remark <= {tbl_mem[lookup_idx][BYTE_PRIORITY][1:0],
                           tbl_mem[lookup_idx][BYTE_REMARK][7]};
      end
   end

   // Checks; all frozen with the rest while ce is low
   // Sampled copies for the table checks below
   logic [2:0] fwd_now;
   logic [7:0] rd_byte_a;
   assign fwd_now = tbl_mem[lookup_idx][BYTE_FORWARD][2:0];
   // Byte A has no masked bits, so a read returns it whole
   assign rd_byte_a = tbl_mem[op_idx_reg][BYTE_PRIORITY];

   AST_LAUNCH: assert property (
      @(posedge pclk) disable iff (!presetn || !ce)
      launch |=> st_reg == AES_BUSY && cnt_reg == XFER_CNT)
      else $error("launch did not start a transfer");

   AST_DONE_TIME: assert property (
      @(posedge pclk) disable iff (!presetn || !ce)
      launch |-> ##[XFER_LAT:XFER_LAT] (done ##1 st_reg == AES_IDLE))
      else $error("transfer length wrong");

   AST_WSTAT: assert property (
      @(posedge pclk) disable iff (!presetn || !ce)
      launch && dir_reg |=> !wstat_reg
      ##[XFER_LAT_M1:XFER_LAT_M1] !wstat_reg ##1 wstat_reg)
      else $error("write status sequence wrong");

   AST_HI_MAP: assert property (
      @(posedge pclk) disable iff (!presetn || !ce)
      done && op_dir_reg && op_en_reg[8]
      |=> tbl_mem[op_idx_reg][7] == $past(stg_reg[7]))
      else $error("high select bit 0 did not write byte 7");

   AST_LO_MAP: assert property (
      @(posedge pclk) disable iff (!presetn || !ce)
      done && op_dir_reg && op_en_reg[0]
      |=> tbl_mem[op_idx_reg][15] == $past(stg_reg[15]))
      else $error("low select bit 0 did not write byte F");

   // Byte F left out of the select, so entry byte F must hold
   AST_KEEP: assert property (
      @(posedge pclk) disable iff (!presetn || !ce)
      done && op_dir_reg && !op_en_reg[0]
      |=> $stable(tbl_mem[op_idx_reg][15]))
      else $error("unselected entry byte changed");

   // Byte A sits behind low select bit 5
   AST_READ_SEL: assert property (
      @(posedge pclk) disable iff (!presetn || !ce)
      done && !op_dir_reg && op_en_reg[5]
      |=> stg_reg[BYTE_PRIORITY] == $past(rd_byte_a))
      else $error("selected byte not read back");

   AST_READ_KEEP: assert property (
      @(posedge pclk) disable iff (!presetn || !ce)
      done && !op_dir_reg && !op_en_reg[2] && !wr_acc
      |=> $stable(stg_reg[13]))
      else $error("unselected staging byte changed on read");

   // Output lags one edge, so it must match the entry seen then
   AST_FWD: assert property (
      @(posedge pclk) disable iff (!presetn || !ce)
      st_reg == AES_IDLE |=> lookup_fwd == $past(fwd_now))
      else $error("forward map output wrong");

endmodule : aes_regs

//--- tb.sv
// Self-checking bench for the ACL staging bytes and byte-select block.
// Assumes aes_pkg and aes_regs; ce stays high, APB driven on pclk.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb
   import aes_pkg::*;
;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic ce = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] lookup_idx = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] lookup_fwd;
   logic [2:0] lookup_remark;
   logic xfer_busy;
   logic [31:0] last_rd;
   logic last_err;
   int failures = 0;
   int total_checks = 0;

   aes_regs aes_regs_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .lookup_idx(lookup_idx), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lookup_fwd(lookup_fwd),
      .lookup_remark(lookup_remark), .xfer_busy(xfer_busy));

   initial begin
      forever #12.5 pclk = ~pclk;
   end

   task automatic final_report();
      if (failures == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   function automatic logic [15:0] ad(input logic [11:0] i);
      return {2'h0, i, 2'h0};
   endfunction : ad

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [15:0] a,
      input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      last_rd = prdata;
      last_err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         failures++;
         final_report();
      end
   endtask : apb

   task automatic wr(input logic [11:0] i, input logic [7:0] d);
      apb(1'h1, ad(i), d);
   endtask : wr

   task automatic rdc(input logic [11:0] i, input logic [31:0] e,
      input string n);
      apb(1'h0, ad(i), 8'h00);
      `CHK(n, e, last_rd)
   endtask : rdc

   // Bounded poll of a status flag in the access control register
   task automatic poll(input int b);
      for (int k = 0; k < 20; k++) begin
         apb(1'h0, ad(IDX_ACCESS_CTRL), 8'h00);
         if (last_rd[b] === 1'h1) begin
            return;
         end
      end
      failures++;
      final_report();
   endtask : poll

   task automatic chk_lookup(input logic [2:0] f, input logic [2:0] r);
      lookup_idx <= 4'h3;
      repeat (2) @(posedge pclk);
      `CHK("lookup_fwd", f, lookup_fwd)
      `CHK("lookup_remark", r, lookup_remark)
   endtask : chk_lookup

   task automatic t_reset();
      rdc(IDX_ACCESS_CTRL, 32'h00000060, "ctrl_reset");
      rdc(IDX_MAC_BYTE_2, 32'h00000000, "mac2_reset");
      rdc(IDX_BYTE_SELECT_LO, 32'h00000000, "sel_lo_reset");
   endtask : t_reset

   task automatic t_access();
      wr(IDX_REMARK_MAP_MODE, 8'hFF);
      rdc(IDX_REMARK_MAP_MODE, 32'h000000E0, "byte_b");
      wr(IDX_SPARE_BYTE, 8'hFF);
      rdc(IDX_SPARE_BYTE, 32'h00000000, "byte_c");
      wr(IDX_FORWARD_PORTS, 8'hFF);
      rdc(IDX_FORWARD_PORTS, 32'h00000007, "byte_d");
      apb(1'h0, 16'h1900, 8'h00);
      `CHK("unmapped_err", 1'h1, last_err)
      apb(1'h0, 16'h1811, 8'h00);
      `CHK("misaligned_err", 1'h1, last_err)
   endtask : t_access

   // Full write of entry 3, then status and lookup outputs
   task automatic t_write();
      wr(IDX_MAC_BYTE_0_LO, 8'h5A);
      wr(IDX_PRIORITY_ACTION, 8'h03);
      wr(IDX_REMARK_MAP_MODE, 8'h00);
      wr(IDX_FORWARD_PORTS, 8'h05);
      wr(IDX_ACCESS_CTRL, 8'h13);
      wr(IDX_BYTE_SELECT_HI, 8'hFF);
      #1 `CHK("busy_after_hi", 1'h0, xfer_busy)
      wr(IDX_BYTE_SELECT_LO, 8'hFF);
      #1 `CHK("busy_after_lo", 1'h1, xfer_busy)
      rdc(IDX_ACCESS_CTRL, 32'h00000033, "wstat_busy");
      poll(CTRL_WSTAT_BIT);
      chk_lookup(3'h5, 3'h6);
   endtask : t_write

   // Only byte D selected: forward map moves, remark stays
   task automatic t_partial();
      wr(IDX_FORWARD_PORTS, 8'h02);
      wr(IDX_PRIORITY_ACTION, 8'h00);
      wr(IDX_BYTE_SELECT_HI, 8'h00);
      wr(IDX_BYTE_SELECT_LO, 8'h04);
      poll(CTRL_WSTAT_BIT);
      chk_lookup(3'h2, 3'h6);
   endtask : t_partial

   // Read back bytes 7 and A only; byte D must stay as staged
   task automatic t_read();
      wr(IDX_MAC_BYTE_0_LO, 8'h00);
      wr(IDX_FORWARD_PORTS, 8'h00);
      wr(IDX_ACCESS_CTRL, 8'h03);
      wr(IDX_BYTE_SELECT_HI, 8'h01);
      wr(IDX_BYTE_SELECT_LO, 8'h20);
      rdc(IDX_ACCESS_CTRL, 32'h00000043, "rstat_busy");
      poll(CTRL_RSTAT_BIT);
      rdc(IDX_MAC_BYTE_0_LO, 32'h0000005A, "byte7_read");
      rdc(IDX_PRIORITY_ACTION, 32'h00000003, "byteA_read");
      rdc(IDX_FORWARD_PORTS, 32'h00000000, "byteD_kept");
   endtask : t_read

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      t_reset();
      t_access();
      t_write();
      t_partial();
      t_read();
      final_report();
   end
endmodule : tb
